// *** hw/adcseq_pkg.sv ***
// Package for the conversion sequencer: register map, field positions,
// reset values, converter timing counts and the state type.
// Assumes a 32-bit AXI4-Lite bus with byte addresses and 8-bit registers.
package adcseq_pkg;
  // Register byte offsets
  localparam logic [7:0] ADCSEQ_CTRL_OFF = 8'h00;
  localparam logic [7:0] ADCSEQ_CLKC_OFF = 8'h04;
  localparam logic [7:0] ADCSEQ_RESH_OFF = 8'h08;
  localparam logic [7:0] ADCSEQ_RESL_OFF = 8'h0C;
  localparam logic [7:0] ADCSEQ_IRQC_OFF = 8'h10;
  localparam logic [7:0] ADCSEQ_PDIR_OFF = 8'h14;
  localparam logic [7:0] ADCSEQ_PPU_OFF = 8'h18;
  // Control register fields
  localparam int ADCSEQ_CHAN_LSB = 0;
  localparam int ADCSEQ_PCFG_LSB = 3;
  localparam int ADCSEQ_PEND_BIT = 6;
  localparam int ADCSEQ_START_BIT = 7;
  // Clock register fields
  localparam int ADCSEQ_DIV_LSB = 0;
  localparam int ADCSEQ_PWROFF_BIT = 7;
  // Interrupt control fields
  localparam int ADCSEQ_GIE_BIT = 0;
  localparam int ADCSEQ_MFIE_BIT = 1;
  localparam int ADCSEQ_CIE_BIT = 2;
  localparam int ADCSEQ_FLAG_BIT = 4;
  // Reset values
  localparam logic [2:0] ADCSEQ_CHAN_RST = 3'h0;
  localparam logic [2:0] ADCSEQ_PCFG_RST = 3'h0;
  localparam logic [2:0] ADCSEQ_DIV_RST = 3'h0;
  localparam logic ADCSEQ_PWROFF_RST = 1'b1;
  localparam logic ADCSEQ_PEND_RST = 1'b1;
  localparam logic [7:0] ADCSEQ_PDIR_RST = 8'hFF;
  localparam logic [7:0] ADCSEQ_PPU_RST = 8'h00;
  // Largest divider code: undivided, /2, /4, /8, /16, /32
  localparam logic [2:0] ADCSEQ_DIV_MAX = 3'h5;
  // Converter timing in converter clock periods
  localparam int ADCSEQ_RES_BITS = 12;
  localparam int ADCSEQ_SAMPLE_TAD = 4;
  localparam int ADCSEQ_CONV_TAD = ADCSEQ_SAMPLE_TAD + ADCSEQ_RES_BITS;
  localparam logic [3:0] ADCSEQ_LAST_SLOT = 4'(ADCSEQ_CONV_TAD - 1);
  localparam logic [3:0] ADCSEQ_SAMPLE_END = 4'(ADCSEQ_SAMPLE_TAD - 1);
  // AXI responses
  localparam logic [1:0] ADCSEQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] ADCSEQ_RESP_SLVERR = 2'h2;
  // Sequencer states, Gray coded in declaration order
  typedef enum logic [1:0] {
    ADCSEQ_IDLE = 2'b00,
    ADCSEQ_SAMPLE = 2'b01,
    ADCSEQ_CONVERT = 2'b11,
    ADCSEQ_HELD = 2'b10
  } adcseq_state_t;
endpackage

// *** hw/adcseq_top.sv ***
// Conversion sequencer around one 12-bit successive-approximation converter:
// pin routing, power gating, start handling, timing and result registers.
// Assumes an analog comparator outside on I_COMP and synchronous inputs.
`timescale 1ns/1ps

module adcseq_top
  import adcseq_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // AXI4-Lite write address and data
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Port pin control
  output logic [7:0] O_PIN_ANALOG,
  output logic [7:0] O_PIN_DIR_INPUT,
  output logic [7:0] O_PIN_PULLUP,
  // Analog front end
  output logic [2:0] O_ANA_SEL,
  output logic O_CONV_POWER,
  output logic O_CONV_RESET,
  output logic O_SAMPLE,
  output logic [11:0] O_DAC_CODE,
  input wire logic I_COMP,
  // Interrupt request to the core
  output logic O_IRQ
);

  // Software-visible state, plus the delayed start bit for edge detection
  logic [2:0] chan_reg;
  logic [2:0] pcfg_reg;
  logic start_reg;
  logic start_prev_reg;
  logic pend_reg;
  logic [2:0] div_reg;
  logic pwroff_reg;
  logic [7:0] res_h_reg;
  logic [7:0] res_l_reg;
  logic gie_reg;
  logic mfie_reg;
  logic cie_reg;
  logic flag_reg;
  logic [7:0] pdir_reg;
  logic [7:0] ppu_reg;

  // Bus slave state
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Sequencer state
  adcseq_state_t state_reg;
  adcseq_state_t state_next;
  logic [4:0] div_cnt_reg;
  logic [3:0] slot_reg;
  logic [11:0] sar_reg;
  logic [11:0] trial_bit;
  logic [9:0] chk_cyc_reg;

  logic wr_fire;
  logic [7:0] wr_byte;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_clkc;
  logic wr_irqc;
  logic conv_en;
  logic start_fall;
  logic tad_tick;
  logic conv_done;
  logic [2:0] div_eff;
  logic [4:0] div_top;
  logic [3:0] pin_count;
  logic [7:0] rd_byte;
  logic rd_ok;

  // Write channel: address and data are taken independently
  assign O_AWREADY = !aw_full_reg && !bvalid_reg;
  assign O_WREADY = !w_full_reg && !bvalid_reg;
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  // Registers are one byte wide, so only lane 0 carries a write
  assign wr_byte = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;
  assign wr_ctrl = wr_fire && wstrb_reg[0] && awaddr_reg == ADCSEQ_CTRL_OFF;
  assign wr_clkc = wr_fire && wstrb_reg[0] && awaddr_reg == ADCSEQ_CLKC_OFF;
  assign wr_irqc = wr_fire && wstrb_reg[0] && awaddr_reg == ADCSEQ_IRQC_OFF;

  // Decode of all mapped offsets; result registers accept and ignore writes
  always_comb begin
    unique case (awaddr_reg)
      ADCSEQ_CTRL_OFF, ADCSEQ_CLKC_OFF, ADCSEQ_RESH_OFF, ADCSEQ_RESL_OFF,
      ADCSEQ_IRQC_OFF, ADCSEQ_PDIR_OFF, ADCSEQ_PPU_OFF: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Write address, data and response handshake
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= ADCSEQ_RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_full_reg <= 1'b1;
        wdata_reg <= I_WDATA;
        wstrb_reg <= I_WSTRB;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? ADCSEQ_RESP_OKAY : ADCSEQ_RESP_SLVERR;
      end else if (bvalid_reg && I_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign O_BVALID = bvalid_reg;
  assign O_BRESP = bresp_reg;

  // Read mux; low result nibble below the data reads as zero
  always_comb begin
    rd_ok = 1'b1;
    unique case (I_ARADDR)
      ADCSEQ_CTRL_OFF: rd_byte = {start_reg, pend_reg, pcfg_reg, chan_reg};
      ADCSEQ_CLKC_OFF: rd_byte = {pwroff_reg, 4'h0, div_reg};
      ADCSEQ_RESH_OFF: rd_byte = res_h_reg;
      ADCSEQ_RESL_OFF: rd_byte = res_l_reg;
      ADCSEQ_IRQC_OFF: rd_byte = {3'h0, flag_reg, 1'b0, cie_reg, mfie_reg,
                                  gie_reg};
      ADCSEQ_PDIR_OFF: rd_byte = pdir_reg;
      ADCSEQ_PPU_OFF: rd_byte = ppu_reg;
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read channel: one read under way at a time
  assign O_ARREADY = !rvalid_reg;
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= ADCSEQ_RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_ok ? ADCSEQ_RESP_OKAY : ADCSEQ_RESP_SLVERR;
    end else if (rvalid_reg && I_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign O_RVALID = rvalid_reg;
  assign O_RDATA = rdata_reg;
  assign O_RRESP = rresp_reg;

  // Register fields written by software
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      chan_reg <= ADCSEQ_CHAN_RST;
      pcfg_reg <= ADCSEQ_PCFG_RST;
      start_reg <= 1'b0;
      div_reg <= ADCSEQ_DIV_RST;
      pwroff_reg <= ADCSEQ_PWROFF_RST;
      pdir_reg <= ADCSEQ_PDIR_RST;
      ppu_reg <= ADCSEQ_PPU_RST;
      gie_reg <= 1'b0;
      mfie_reg <= 1'b0;
      cie_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        chan_reg <= wr_byte[ADCSEQ_CHAN_LSB +: 3];
        pcfg_reg <= wr_byte[ADCSEQ_PCFG_LSB +: 3];
        start_reg <= wr_byte[ADCSEQ_START_BIT];
      end
      if (wr_clkc) begin
        div_reg <= wr_byte[ADCSEQ_DIV_LSB +: 3];
        pwroff_reg <= wr_byte[ADCSEQ_PWROFF_BIT];
      end
      if (wr_irqc) begin
        gie_reg <= wr_byte[ADCSEQ_GIE_BIT];
        mfie_reg <= wr_byte[ADCSEQ_MFIE_BIT];
        cie_reg <= wr_byte[ADCSEQ_CIE_BIT];
      end
      if (wr_fire && wstrb_reg[0] && awaddr_reg == ADCSEQ_PDIR_OFF) begin
        pdir_reg <= wr_byte;
      end
      if (wr_fire && wstrb_reg[0] && awaddr_reg == ADCSEQ_PPU_OFF) begin
        ppu_reg <= wr_byte;
      end
    end
  end

  // Pin routing: config n gives 2n analog pins from pin 0, capped at eight
  assign pin_count = (pcfg_reg >= 3'h4) ? 4'h8 : {pcfg_reg, 1'b0};
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      O_PIN_ANALOG[i] = 4'(i) < pin_count;
    end
  end
  // Analog pins read as inputs whatever the direction register holds
  assign O_PIN_DIR_INPUT = pdir_reg | O_PIN_ANALOG;
  // Pull-ups only on digital pins
  assign O_PIN_PULLUP = ppu_reg & ~O_PIN_ANALOG;
  assign O_ANA_SEL = chan_reg;

  // Power gating
  assign conv_en = !pwroff_reg && pcfg_reg != 3'h0;
  assign O_CONV_POWER = conv_en;

  // Converter clock: codes above the largest ratio use the largest
  assign div_eff = (div_reg > ADCSEQ_DIV_MAX) ? ADCSEQ_DIV_MAX : div_reg;
  assign div_top = 5'((6'h01 << div_eff) - 6'h01);
  assign tad_tick = div_cnt_reg == div_top;
  // The divider restarts with each conversion so the first period is whole
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      div_cnt_reg <= 5'h00;
    end else if (state_reg == ADCSEQ_IDLE || state_reg == ADCSEQ_HELD ||
                 tad_tick) begin
      div_cnt_reg <= 5'h00;
    end else begin
      div_cnt_reg <= 5'(div_cnt_reg + 5'h01);
    end
  end

  // Start edge detection
  assign start_fall = start_prev_reg && !start_reg;
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_reg;
    end
  end

  // An abort or a fresh start in the last period must not complete
  assign conv_done = state_reg == ADCSEQ_CONVERT && tad_tick &&
                     slot_reg == ADCSEQ_LAST_SLOT && conv_en && !start_reg;

  // Sequencer; a start bit left high holds the converter in reset
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ADCSEQ_IDLE: if (start_reg) state_next = ADCSEQ_HELD;
      ADCSEQ_HELD: begin
        if (start_fall) begin
          state_next = conv_en ? ADCSEQ_SAMPLE : ADCSEQ_IDLE;
        end
      end
      ADCSEQ_SAMPLE: begin
        if (start_reg) begin
          state_next = ADCSEQ_HELD;
        end else if (!conv_en) begin
          state_next = ADCSEQ_IDLE;
        end else if (tad_tick && slot_reg == ADCSEQ_SAMPLE_END) begin
          state_next = ADCSEQ_CONVERT;
        end
      end
      ADCSEQ_CONVERT: begin
        if (start_reg) begin
          state_next = ADCSEQ_HELD;
        end else if (!conv_en || conv_done) begin
          state_next = ADCSEQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= ADCSEQ_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Slot counter: slots 0..3 sample, 4..15 resolve bits 11 down to 0
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      slot_reg <= 4'h0;
    end else if (state_reg == ADCSEQ_IDLE || state_reg == ADCSEQ_HELD) begin
      slot_reg <= 4'h0;
    end else if (tad_tick) begin
      slot_reg <= 4'(slot_reg + 4'h1);
    end
  end

  // Successive approximation: keep the trial bit when input is above it
  assign trial_bit = (state_reg == ADCSEQ_CONVERT) ?
                     12'(12'h800 >> (slot_reg - ADCSEQ_SAMPLE_TAD)) : 12'h000;
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      sar_reg <= 12'h000;
    end else if (state_reg == ADCSEQ_SAMPLE) begin
      sar_reg <= 12'h000;
    end else if (state_reg == ADCSEQ_CONVERT && tad_tick && I_COMP) begin
      sar_reg <= sar_reg | trial_bit;
    end
  end
  assign O_DAC_CODE = sar_reg | trial_bit;
  assign O_SAMPLE = state_reg == ADCSEQ_SAMPLE;
  assign O_CONV_RESET = state_reg == ADCSEQ_HELD || !conv_en;

  // Results land together with the pending flag falling
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      res_h_reg <= 8'h00;
      res_l_reg <= 8'h00;
    end else if (conv_done) begin
      res_h_reg <= 8'((sar_reg | (trial_bit & {12{I_COMP}})) >> 4);
      res_l_reg <= {(sar_reg[3:0] | (I_COMP ? trial_bit[3:0] : 4'h0)),
                    4'h0};
    end
  end

  // Pending flag: raised by the start bit, cleared only by completion
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      pend_reg <= ADCSEQ_PEND_RST;
    end else if (start_reg) begin
      pend_reg <= 1'b1;
    end else if (conv_done) begin
      pend_reg <= 1'b0;
    end
  end

  // Request flag: completion wins over a software clear in the same cycle
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      flag_reg <= 1'b0;
    end else if (conv_done) begin
      flag_reg <= 1'b1;
    end else if (wr_irqc && !wr_byte[ADCSEQ_FLAG_BIT]) begin
      flag_reg <= 1'b0;
    end
  end
  assign O_IRQ = flag_reg && gie_reg && mfie_reg && cie_reg;

  // Cycles spent in the current conversion, read only by the length check
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      chk_cyc_reg <= 10'h000;
    end else if (O_SAMPLE || state_reg == ADCSEQ_CONVERT) begin
      chk_cyc_reg <= 10'(chk_cyc_reg + 10'h001);
    end else begin
      chk_cyc_reg <= 10'h000;
    end
  end

  // Checks
  a_all_analog: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    pcfg_reg == 3'h7 |-> O_PIN_ANALOG == 8'hFF)
    else $error("config 7 did not make all pins analog");
  a_pullup_digital: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    (O_PIN_PULLUP & O_PIN_ANALOG) == 8'h00)
    else $error("pull-up left on an analog pin");
  a_analog_input: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    (O_PIN_ANALOG & ~O_PIN_DIR_INPUT) == 8'h00)
    else $error("analog pin not forced to input");
  a_power_gate: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    (pcfg_reg == 3'h0 || pwroff_reg) |-> !O_CONV_POWER)
    else $error("converter powered while disabled");
  a_start_held: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    start_reg [*2] |-> pend_reg && state_reg == ADCSEQ_HELD)
    else $error("held start did not reset and flag pending");
  a_done_result: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    conv_done |=> !pend_reg && flag_reg && res_l_reg[3:0] == 4'h0)
    else $error("completion did not clear pending and set flag");
  a_conv_length: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    conv_done |-> chk_cyc_reg == 10'((ADCSEQ_CONV_TAD << div_eff) - 1))
    else $error("conversion did not take sixteen periods");
  a_irq_gated: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    conv_done && !wr_irqc && gie_reg && mfie_reg && cie_reg |=> O_IRQ)
    else $error("completion with all enables gave no interrupt");
  a_start_begins: assert property (
    @(posedge I_MCLK) disable iff (I_RST)
    (state_reg == ADCSEQ_HELD && !start_reg && conv_en) |=>
      state_reg == ADCSEQ_SAMPLE && pend_reg)
    else $error("start pulse did not begin sampling");

endmodule // adcseq_top

// *** tb/adcseq_analog_model.sv ***
// Far-side model: eight analog inputs, a sample-and-hold and a comparator
// against the converter's trial code.
// Assumes levels arrive as 12-bit codes, channel 0 in the low bits.
`timescale 1ns/1ps
module adcseq_analog_model (
  // Clock
  input wire logic i_clk,
  // Levels of all eight inputs
  input wire logic [95:0] i_level,
  // Converter side
  input wire logic [2:0] i_sel,
  input wire logic i_sample,
  input wire logic i_power,
  input wire logic [11:0] i_dac,
  output logic o_comp
);
  logic [11:0] held_reg = 12'h000;
  logic toggle_reg = 1'b0;

  // Track the routed input while sampling, freeze it for the bit trials
  always_ff @(posedge i_clk) begin
    if (i_sample) begin
      held_reg <= i_level[i_sel * 12 +: 12];
    end
    toggle_reg <= ~toggle_reg;
  end

  // Level sits half a step above its code, so a tie can never occur;
  // an unpowered comparator gives a toggling value, not a stale one
  assign o_comp = i_power ? ({held_reg, 1'b1} > {i_dac, 1'b0}) : toggle_reg;
endmodule // adcseq_analog_model

// *** tb/adcseq_top_bench.sv ***
// Self-checking bench for the conversion sequencer: AXI4-Lite tasks,
// a register model and the analog front-end partner.
// Assumes the package register map and the hand-over latencies.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  fail_count++; $display("FAIL %s expected %h seen %h", nm, e, g); end end

module adcseq_top_bench;
  import adcseq_pkg::*;
  logic clk = 1'b0, rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h1;
  logic [2:0] prot = 3'h0;
  logic [95:0] level = '0;
  logic awready, wready, bvalid, arready, rvalid, comp, power;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pin_an, pin_dir, pin_pu;
  logic [2:0] ana_sel;
  logic conv_reset, sample, irq, run = 1'b0;
  logic [11:0] dac;
  int n_tests = 0, fail_count = 0, seed, s_cnt = 0, c_cnt = 0;
  // Register model
  int ctrl_m = 0, clkc_m = 8'h80, irqc_m = 0, pdir_m = 8'hFF, ppu_m = 0;
  int res_m = 0, pend_m = 1, flag_m = 0;

  adcseq_top u_adcseq_top (
    .I_MCLK(clk), .I_RST(rst), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_AWADDR(awaddr), .I_AWPROT(prot), .I_WVALID(wvalid),
    .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
    .I_ARPROT(prot), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_PIN_ANALOG(pin_an),
    .O_PIN_DIR_INPUT(pin_dir), .O_PIN_PULLUP(pin_pu), .O_ANA_SEL(ana_sel),
    .O_CONV_POWER(power), .O_CONV_RESET(conv_reset), .O_SAMPLE(sample),
    .O_DAC_CODE(dac), .I_COMP(comp), .O_IRQ(irq)
  );
  adcseq_analog_model u_adcseq_analog_model (
    .i_clk(clk), .i_level(level), .i_sel(ana_sel), .i_sample(sample),
    .i_power(power), .i_dac(dac), .o_comp(comp)
  );

  // Clock, 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end

  // Count sampling cycles and cycles from sampling until the interrupt
  always @(posedge clk) begin
    if (sample) s_cnt++;
    if ((sample || run) && !irq) c_cnt++;
    if (sample) run = 1'b1;
  end

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      ADCSEQ_CTRL_OFF: return 32'(ctrl_m | (pend_m << ADCSEQ_PEND_BIT));
      ADCSEQ_CLKC_OFF: return 32'(clkc_m);
      ADCSEQ_RESH_OFF: return 32'(res_m >> 4);
      ADCSEQ_RESL_OFF: return 32'((res_m & 15) << 4);
      ADCSEQ_IRQC_OFF: return 32'(irqc_m | (flag_m << ADCSEQ_FLAG_BIT));
      ADCSEQ_PDIR_OFF: return 32'(pdir_m);
      ADCSEQ_PPU_OFF: return 32'(ppu_m);
      default: return 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    if (a > ADCSEQ_PPU_OFF) return ADCSEQ_RESP_SLVERR;
    return ADCSEQ_RESP_OKAY;
  endfunction

  // Model update first, then one AXI write with both channels offered
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    int t;
    logic [1:0] resp;
    case (a)
      ADCSEQ_CTRL_OFF: begin
        ctrl_m = d & 8'hBF;
        if (d[ADCSEQ_START_BIT]) pend_m = 1;
      end
      ADCSEQ_CLKC_OFF: clkc_m = d & 8'h87;
      ADCSEQ_IRQC_OFF: begin
        irqc_m = d & 8'h07;
        if (!d[ADCSEQ_FLAG_BIT]) flag_m = 0;
      end
      ADCSEQ_PDIR_OFF: pdir_m = d;
      ADCSEQ_PPU_OFF: ppu_m = d;
      default: ;
    endcase
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 40; t++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    `CHK("bresp", exp_resp(a), resp)
  endtask

  // One AXI read compared with the model
  task automatic rd_chk(input logic [7:0] a);
    int t;
    logic [31:0] d;
    logic [1:0] resp;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 40; t++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    `CHK("rdata", exp_rd(a), d)
    `CHK("rresp", exp_resp(a), resp)
  endtask

  // Pin function outputs against the model's configuration
  task automatic chk_pins;
    int n;
    logic [7:0] m;
    n = (ctrl_m >> ADCSEQ_PCFG_LSB) & 7;
    m = (n >= 4) ? 8'hFF : 8'((1 << (2 * n)) - 1);
    @(negedge clk);
    `CHK("analog", m, pin_an)
    `CHK("dir", 8'(pdir_m) | m, pin_dir)
    `CHK("pullup", 8'(ppu_m) & ~m, pin_pu)
    `CHK("chan", 3'(ctrl_m), ana_sel)
    `CHK("power", 1'(n != 0 && clkc_m < 128), power)
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [95:0] lv;
    logic [7:0] wl [5];
    int a, k, ch, d, t;
    seed = 32'hdc1d_4bd1;
    wl = '{ADCSEQ_RESH_OFF, ADCSEQ_RESL_OFF, ADCSEQ_PDIR_OFF,
           ADCSEQ_PPU_OFF, 8'h1C};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values, plus one address past the map
    for (a = 0; a <= 28; a += 4) rd_chk(8'(a));
    // Results ignore writes; the hole answers with an error
    foreach (wl[i]) begin
      reg_wr(wl[i], 8'($random(seed)));
      rd_chk(wl[i]);
    end
    // Every pin setting, start held high so the converter stays reset
    for (k = 0; k < 8; k++) begin
      reg_wr(ADCSEQ_CLKC_OFF, 8'($random(seed)) & 8'h80);
      reg_wr(ADCSEQ_CTRL_OFF, 8'h80 | 8'(k << 3) | 8'($random(seed) & 7));
      chk_pins();
      `CHK("held", 1'b1, conv_reset)
      rd_chk(ADCSEQ_CTRL_OFF);
    end
    // Start left low with the converter off before the first pulse
    reg_wr(ADCSEQ_CLKC_OFF, 8'h80);
    reg_wr(ADCSEQ_CTRL_OFF, 8'h38);
    // One conversion per divider code 0 to 6, random level on a random input
    for (k = 0; k < 7; k++) begin
      ch = $random(seed) & 7;
      lv = {$random(seed), $random(seed), $random(seed)};
      level <= lv;
      d = (k > 5) ? 5 : k;
      reg_wr(ADCSEQ_IRQC_OFF, 8'h07);
      reg_wr(ADCSEQ_CTRL_OFF, 8'(8'hB8 | ch));
      reg_wr(ADCSEQ_CLKC_OFF, 8'(k));
      @(negedge clk);
      s_cnt = 0;
      c_cnt = 0;
      run = 1'b0;
      reg_wr(ADCSEQ_CTRL_OFF, 8'(8'h38 | ch));
      rd_chk(ADCSEQ_CTRL_OFF);
      for (t = 0; t < 1200 && !irq; t++) @(posedge clk);
      @(negedge clk);
      `CHK("sample", 4 << d, s_cnt)
      `CHK("convert", 16 << d, c_cnt)
      pend_m = 0;
      flag_m = 1;
      res_m = lv[ch * 12 +: 12];
      `CHK("irq", 1'b1, irq)
      rd_chk(ADCSEQ_CTRL_OFF);
      rd_chk(ADCSEQ_RESH_OFF);
      rd_chk(ADCSEQ_RESL_OFF);
      rd_chk(ADCSEQ_IRQC_OFF);
      // Flag kept set (writing one is ignored) under every enable mix
      if (k == 0) begin
        for (t = 0; t < 8; t++) begin
          reg_wr(ADCSEQ_IRQC_OFF, 8'(8'h10 | t));
          @(negedge clk);
          `CHK("irq mask", 1'(t == 7), irq)
        end
      end
    end
    // Power removed mid-conversion: no result, pending stays high
    reg_wr(ADCSEQ_IRQC_OFF, 8'h07);
    reg_wr(ADCSEQ_CTRL_OFF, 8'hB8);
    reg_wr(ADCSEQ_CLKC_OFF, 8'h05);
    reg_wr(ADCSEQ_CTRL_OFF, 8'h38);
    reg_wr(ADCSEQ_CLKC_OFF, 8'h85);
    repeat (600) @(posedge clk);
    @(negedge clk);
    `CHK("no irq", 1'b0, irq)
    rd_chk(ADCSEQ_CTRL_OFF);
    rd_chk(ADCSEQ_RESH_OFF);
    // Power bit on, config cleared with no start pulse: pins digital again
    reg_wr(ADCSEQ_CLKC_OFF, 8'h05);
    reg_wr(ADCSEQ_CTRL_OFF, 8'h00);
    chk_pins();
    rd_chk(ADCSEQ_CTRL_OFF);
    tally_and_finish();
  end

  // Watchdog, well beyond the expected few thousand cycles
  initial begin
    #(8 * 30000);
    fail_count++;
    tally_and_finish();
  end
endmodule // adcseq_top_bench
